// file: src/phase_step_pkg.sv
/*
  Constants shared by the phase-step and counter-bypass control block:
  select codes, bypass field layout, phase tap geometry and step timing.
  Assumes a single synchronous reconfiguration clock domain.
*/
package phase_step_pkg;

  // ----------------------------------------------------------------------
  // Counter select codes
  // ----------------------------------------------------------------------
  localparam int unsigned SEL_W        = 4;
  localparam logic [3:0]  SEL_ALL_OUT  = 4'h0;
  localparam logic [3:0]  SEL_MULT     = 4'h1;
  localparam logic [3:0]  SEL_OUT_BASE = 4'h2;
  localparam logic [3:0]  SEL_OUT_LAST = 4'hB;
  localparam int unsigned NUM_OUT      = 10;

  // ----------------------------------------------------------------------
  // Bypass setting field layout
  // ----------------------------------------------------------------------
  localparam int unsigned BYP_FIELD_W   = 9;
  localparam int unsigned BYP_CTRL_BIT  = 8;
  localparam int unsigned CNT_VALUE_W   = 16;
  localparam logic [7:0]  CNT_DIV_ONE   = 8'h01;
  localparam logic        POST_BYPASS_V = 1'b0;

  // ----------------------------------------------------------------------
  // Phase tap geometry and step timing
  // ----------------------------------------------------------------------
  localparam int unsigned TAP_W        = 3;
  localparam logic [2:0]  TAP_RESET    = 3'h0;
  localparam logic [2:0]  TAP_ONE      = 3'h1;
  localparam int unsigned SHIFT_CYC    = 1;
  localparam int unsigned LATCH_EDGES  = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT, ST_HOLD} step_state_t;

endpackage

// file: src/pll_phase_step_and_bypass.sv
/*
  Phase step sequencer and per-counter bypass decode for a clock
  synthesizer. Holds one eighth-period phase tap for the multiplier and each output counter.
  Assumes core_clk is the free-running reconfiguration clock and that
  the step inputs are synchronous to it.
*/
// Notes on behaviour
// RULE1 - A bypassed counter acts as multiply-by-one or divide-by-one.
// RULE2 - Bypass field is nine bits, LSB first; bit 8 zero means normal division.
// RULE3 - Bit 8 set bypasses the counter and ignores all other field bits.
// RULE4 - The post-scale divider bit bypasses on zero.
// RULE5 - Each counter segment carries a bypass bit and an odd-duty bit; here only the output counters take an odd-duty input.
// RULE6 - Phase steps move the tap of the selected counter without chain reload.
// RULE7 - Each step moves one eighth VCO period; outputs keep running.
// RULE8 - Four-bit select decodes multiplier, one output, or all outputs; registered.
// RULE9 - Code 0 all outputs, 1 multiplier, 2 to 11 outputs C0 to C9.
// RULE10 - Direction 1 shifts later, 0 shifts earlier; registered on rising edge.
// RULE11 - Step request is sampled on the falling clock edge.
// RULE12 - Controller sets direction and select, then holds request two cycles.
// RULE13 - Controller drops request only after completion flag goes low.
// RULE14 - Second rising edge after latch captures inputs and drops completion.
// RULE15 - Completion stays low until shift ends, then rises on internal timing.
// RULE16 - Controller starts no new step until completion returns high.
// RULE17 - Each request pulse yields exactly one step however long held.
// RULE18 - Request pulses are separated by at least one low cycle.
// RULE19 - Steps are unlimited and phase taps wrap around.
// RULE20 - The reconfiguration clock is free running from the core.
// RULE21 - Completion flag is high while no step is pending or running.
`timescale 1ns/1ps
module pll_phase_step_and_bypass
  import phase_step_pkg::*;
#(
  parameter int unsigned NUM_OUTPUTS = phase_step_pkg::NUM_OUT,
  parameter int unsigned SHIFT_CYCLES = phase_step_pkg::SHIFT_CYC
) (
  // Clock, reset and enable
  input  wire logic                                         core_clk,
  input  wire logic                                         reset,
  input  wire logic                                         clk_en,
  // Phase step handshake
  input  wire logic [phase_step_pkg::SEL_W-1:0]             step_target_sel,
  input  wire logic                                         step_direction,
  input  wire logic                                         step_request,
  output logic                                              step_complete,
  // Bypass setting fields, multiplier, pre-divider and outputs
  input  wire logic [phase_step_pkg::BYP_FIELD_W-1:0]       mult_bypass_field,
  input  wire logic [phase_step_pkg::BYP_FIELD_W-1:0]       prediv_bypass_field,
  input  wire logic [NUM_OUTPUTS*phase_step_pkg::BYP_FIELD_W-1:0] out_bypass_fields,
  input  wire logic                                         post_scale_bit,
  input  wire logic [NUM_OUTPUTS-1:0]                       out_odd_duty,
  // Effective counter configuration
  output logic                                              mult_bypassed,
  output logic                                              prediv_bypassed,
  output logic [NUM_OUTPUTS-1:0]                            out_bypassed,
  output logic [NUM_OUTPUTS-1:0]                            out_odd_duty_eff,
  output logic                                              post_scale_bypassed,
  // Phase tap selections, one eighth VCO period per tap
  output logic [phase_step_pkg::TAP_W-1:0]                  mult_tap,
  output logic [NUM_OUTPUTS*phase_step_pkg::TAP_W-1:0]      out_taps
);

  // ----------------------------------------------------------------------
  // Request sampling on the falling edge
  // ----------------------------------------------------------------------
  logic req_fall_r;
  logic req_seen_r;
  // RULE11 falling edge sample
  always_ff @(negedge core_clk or posedge reset) begin
    if (reset) begin
      req_fall_r <= 1'b0;
    end else if (clk_en) begin
      req_fall_r <= step_request;
    end
  end

  // ----------------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------------
  step_state_t state_r;
  logic [1:0]  edge_cnt_r;
  logic [7:0]  shift_cnt_r;
  logic [3:0]  sel_r;
  logic        dir_r;
  logic        armed_r;
  logic        do_shift;

  // RULE17 one step per pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      armed_r <= 1'b1;
    end else if (clk_en) begin
      if (!req_fall_r) begin
        armed_r <= 1'b1;
      end else if (state_r == ST_IDLE && armed_r) begin
        armed_r <= 1'b0;
      end
    end
  end

  assign req_seen_r = req_fall_r && armed_r;

  // RULE14 capture on second edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r     <= ST_IDLE;
      edge_cnt_r  <= 2'h0;
      shift_cnt_r <= 8'h00;
      sel_r       <= SEL_ALL_OUT;
      dir_r       <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          if (req_seen_r) begin
            state_r    <= ST_WAIT;
            edge_cnt_r <= 2'h1;
          end
        end
        ST_WAIT: begin
          if (edge_cnt_r == 2'(LATCH_EDGES - 1)) begin
            // RULE8 registered select
            sel_r       <= step_target_sel;
            // RULE10 registered direction
            dir_r       <= step_direction;
            shift_cnt_r <= 8'(SHIFT_CYCLES);
            state_r     <= ST_SHIFT;
          end else begin
            edge_cnt_r <= edge_cnt_r + 2'h1;
          end
        end
        ST_SHIFT: begin
          // RULE15 internal shift timing
          if (shift_cnt_r <= 8'h01) begin
            state_r <= ST_IDLE;
          end else begin
            shift_cnt_r <= shift_cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign do_shift = clk_en && (state_r == ST_SHIFT) && (shift_cnt_r <= 8'h01);

  // RULE21 completion high when idle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step_complete <= 1'b1;
    end else if (clk_en) begin
      if (state_r == ST_WAIT && edge_cnt_r == 2'(LATCH_EDGES - 1)) begin
        step_complete <= 1'b0;
      end else if (state_r == ST_SHIFT && shift_cnt_r <= 8'h01) begin
        step_complete <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Phase taps
  // ----------------------------------------------------------------------
  // Taps wrap modulo eight, so stepping never saturates.
  // RULE6 tap moves without reload
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mult_tap <= TAP_RESET;
    end else if (do_shift && sel_r == SEL_MULT) begin
      // RULE7 one eighth step
      mult_tap <= dir_r ? mult_tap + TAP_ONE : mult_tap - TAP_ONE;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_out
      logic hit;
      // RULE9 select decode
      assign hit = (sel_r == SEL_ALL_OUT) || (sel_r == 4'(SEL_OUT_BASE + gi));
      // RULE19 unlimited wrapping steps
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          out_taps[gi*TAP_W +: TAP_W] <= TAP_RESET;
        end else if (do_shift && hit) begin
          out_taps[gi*TAP_W +: TAP_W] <= dir_r ? out_taps[gi*TAP_W +: TAP_W] + TAP_ONE
                                               : out_taps[gi*TAP_W +: TAP_W] - TAP_ONE;
        end
      end
      // RULE3 bypass bit overrides field
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          out_bypassed[gi]     <= 1'b0;
          out_odd_duty_eff[gi] <= 1'b0;
        end else if (clk_en) begin
          out_bypassed[gi]     <= out_bypass_fields[gi*BYP_FIELD_W + BYP_CTRL_BIT];
          // RULE5 odd-duty ignored when bypassed
          out_odd_duty_eff[gi] <= out_odd_duty[gi]
                                  && !out_bypass_fields[gi*BYP_FIELD_W + BYP_CTRL_BIT];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Bypass decode for multiplier, pre-divider and post-scale divider
  // ----------------------------------------------------------------------
  // RULE1 bypass gives factor one
  // RULE2 bit eight is control
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mult_bypassed       <= 1'b0;
      prediv_bypassed     <= 1'b0;
      post_scale_bypassed <= 1'b0;
    end else if (clk_en) begin
      mult_bypassed       <= mult_bypass_field[BYP_CTRL_BIT];
      prediv_bypassed     <= prediv_bypass_field[BYP_CTRL_BIT];
      // RULE4 inverted sense bit
      post_scale_bypassed <= (post_scale_bit == POST_BYPASS_V);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Counts enabled cycles with the completion flag low, so that the check
  // below holds for any shift length from 1 to 255 and not only for the default one.
  logic [7:0] low_cnt_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      low_cnt_r <= 8'h00;
    end else if (clk_en) begin
      low_cnt_r <= step_complete ? 8'h00 : low_cnt_r + 8'h01;
    end
  end

  capture_drop_a: assert property (@(posedge core_clk) disable iff (reset) // RULE14
    (clk_en && state_r == ST_WAIT && edge_cnt_r == 2'(LATCH_EDGES - 1))
      |=> !step_complete)
    else $error("completion did not drop at capture edge");

  idle_high_a: assert property (@(posedge core_clk) disable iff (reset) // RULE21
    (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> step_complete)
    else $error("completion low while idle");

  shift_end_a: assert property (@(posedge core_clk) disable iff (reset) // RULE15
    !step_complete |-> low_cnt_r < 8'(SHIFT_CYCLES))
    else $error("completion stayed low too long");

  one_step_a: assert property (@(posedge core_clk) disable iff (reset) // RULE17
    (state_r == ST_IDLE && !armed_r) |=> state_r == ST_IDLE)
    else $error("held request started a second step");

  mult_wrap_a: assert property (@(posedge core_clk) disable iff (reset) // RULE7
    (do_shift && sel_r == SEL_MULT && dir_r) |=> mult_tap == $past(mult_tap) + TAP_ONE)
    else $error("multiplier tap did not advance one step");

  bypass_map_a: assert property (@(posedge core_clk) disable iff (reset) // RULE2
    clk_en |=> mult_bypassed == $past(mult_bypass_field[BYP_CTRL_BIT]))
    else $error("multiplier bypass not taken from control bit");

  post_inv_a: assert property (@(posedge core_clk) disable iff (reset) // RULE4
    (clk_en && !post_scale_bit) |=> post_scale_bypassed)
    else $error("post-scale zero did not bypass");

  wait_two_a: assert property (@(posedge core_clk) disable iff (reset) // RULE11
    (state_r == ST_IDLE && $past(state_r) == ST_IDLE && clk_en && req_seen_r)
      |=> state_r == ST_WAIT ##1 (!clk_en || state_r == ST_SHIFT || state_r == ST_WAIT))
    else $error("request not followed into wait");

endmodule

// file: verification/step_driver.sv
/*
  Core-side model that issues single phase steps on command.
  Assumes one free-running clock shared with the block under test.
*/
`timescale 1ns/1ps
module step_driver (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Bench commands
  input  wire logic       go,
  input  wire logic       hold_long,
  input  wire logic [3:0] sel_in,
  input  wire logic       dir_in,
  output logic            busy,
  // Step handshake
  output logic [3:0]      step_target_sel,
  output logic            step_direction,
  output logic            step_request,
  input  wire logic       step_complete
);
  int n;
  // A wait that runs out leaves busy high, so the bench times out and fails.
  bit stuck = 1'b0;
  // --------------------------------------------------------------------
  // Step sequencer
  // --------------------------------------------------------------------
  // The flag is read first on a rising edge, then on falling edges clear of the edge that moves it.
  initial begin
    {busy, step_request, step_direction, step_target_sel} = '0;
    wait (reset === 1'b0);
    forever begin
      @(posedge core_clk);
      if (go) begin
        busy <= 1'b1;
        step_target_sel <= sel_in;
        step_direction <= dir_in;
        @(posedge core_clk);
        step_request <= 1'b1;
        repeat (2) @(posedge core_clk);
        n = 0;
        while (step_complete !== 1'b0 && n < 20) begin
          @(negedge core_clk);
          n++;
        end
        if (n >= 20) stuck = 1'b1;
        // A long hold must still give only one step.
        if (hold_long) repeat (6) @(posedge core_clk);
        @(posedge core_clk);
        step_request <= 1'b0;
        n = 0;
        while (step_complete !== 1'b1 && n < 20) begin
          @(negedge core_clk);
          n++;
        end
        if (n >= 20) stuck = 1'b1;
        @(posedge core_clk);
        if (!stuck) busy <= 1'b0;
      end
    end
  end
endmodule

// file: verification/tb.sv
/*
  Self-checking bench for the phase step and bypass block.
  Assumes the core-side model drives the step handshake.
*/
`timescale 1ns/1ps
module tb;
  import phase_step_pkg::*;
  localparam int unsigned SHIFT = 3;
  logic core_clk, reset, go, hold_long, dir_in, busy, b;
  logic step_direction, step_request, step_complete;
  logic [3:0] sel_in, step_target_sel;
  logic [8:0] mult_f, prediv_f;
  logic [89:0] out_f;
  logic post_bit, mult_byp, prediv_byp, post_byp;
  logic [9:0] odd, out_byp, odd_eff, ob;
  logic [2:0] mult_tap, exp_m;
  logic [29:0] out_taps, exp_o;
  int errors, comparisons, low_n;

  pll_phase_step_and_bypass #(.SHIFT_CYCLES(SHIFT)) dut (
    .core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .step_target_sel(step_target_sel), .step_direction(step_direction),
    .step_request(step_request), .step_complete(step_complete),
    .mult_bypass_field(mult_f), .prediv_bypass_field(prediv_f),
    .out_bypass_fields(out_f), .post_scale_bit(post_bit), .out_odd_duty(odd),
    .mult_bypassed(mult_byp), .prediv_bypassed(prediv_byp),
    .out_bypassed(out_byp), .out_odd_duty_eff(odd_eff),
    .post_scale_bypassed(post_byp), .mult_tap(mult_tap), .out_taps(out_taps));

  step_driver core (
    .core_clk(core_clk), .reset(reset), .go(go), .hold_long(hold_long),
    .sel_in(sel_in), .dir_in(dir_in), .busy(busy),
    .step_target_sel(step_target_sel), .step_direction(step_direction),
    .step_request(step_request), .step_complete(step_complete));

  // --------------------------------------------------------------------
  // Clock and checking helpers
  // --------------------------------------------------------------------
  // free running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Each finished low stretch of the flag must last the shift time.
  always @(negedge core_clk) begin
    if (reset === 1'b0 && step_complete === 1'b0)
      low_n++;
    else if (low_n != 0) begin
      check("complete low cycles", SHIFT, low_n);
      low_n = 0;
    end
  end

  // One step through the core model, then tap comparison.
  task automatic step(input logic [3:0] s, input logic d, input logic h);
    int k;
    logic [2:0] inc;
    k = 0;
    inc = d ? TAP_ONE : 3'h7;
    @(posedge core_clk);
    {sel_in, dir_in, hold_long, go} <= {s, d, h, 1'b1};
    @(posedge core_clk);
    go <= 1'b0;
    do begin
      @(posedge core_clk);
      k++;
    end while (busy !== 1'b0 && k < 100);
    if (k >= 100) begin
      errors++;
      end_of_test();
    end
    if (s == SEL_ALL_OUT)
      for (int i = 0; i < 10; i++) exp_o[3*i+:3] += inc;
    else if (s == SEL_MULT)
      exp_m += inc;
    else
      exp_o[3*(int'(s)-2)+:3] += inc;
    check("mult tap", exp_m, mult_tap);
    check("out taps", exp_o, out_taps);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {reset, go, hold_long, dir_in, sel_in, post_bit} = {1'b1, 8'h00};
    {mult_f, prediv_f, out_f, odd} = '0;
    {exp_m, exp_o, errors, comparisons, low_n} = '0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check("idle complete", 1'b1, step_complete);
    check("reset mult tap", 3'h0, mult_tap);
    check("reset out taps", 30'h0, out_taps);
    // Select codes 0 to 11, alternating direction; code 0 wraps down.
    for (int s = 0; s < 12; s++) step(s[3:0], s[0], 1'b0);
    $display("test select_codes done");
    step(SEL_MULT, 1'b0, 1'b1);
    $display("test long_hold done");
    repeat (9) step(SEL_OUT_LAST, 1'b1, 1'b0);
    $display("test wrap done");
    // Both bypass senses, with the other multiplier and output field bits set to noise.
    for (int p = 0; p < 2; p++) begin
      b = (p == 0);
      ob = b ? 10'h155 : 10'h2AA;
      @(posedge core_clk);
      mult_f <= {b, 8'hA5};
      prediv_f <= {~b, 8'h00};
      post_bit <= ~b;
      odd <= 10'h3FF;
      for (int i = 0; i < 10; i++) out_f[9*i+:9] <= {b ^ i[0], 8'hFF};
      repeat (2) @(posedge core_clk);
      #1;
      check("mult bypass", b, mult_byp);
      check("prediv bypass", !b, prediv_byp);
      check("out bypass", ob, out_byp);
      check("post bypass", b, post_byp);
      check("odd duty", 10'(~ob), odd_eff);
    end
    $display("test bypass done");
    end_of_test();
  end
endmodule
